// ==== src/ilhm_top.v ====
// Purpose: per-track high-pass, limiter and monitor-tap selection for two tracks
// Assumes: one sample pair per accepted input beat; hclk 50 MHz; AHB-Lite slave
// Notes:   attack/release/look-ahead times are counted in samples at the set rate
//
// Summary of operation
// - monitor tap prefader or postfader per track
// - playback with monitor screen forces postfader tap
// - high-pass bypassed or cutoff 10 to 240 Hz
// - limiter off, ordinary or look-ahead; off passes
// - above threshold, limiter reduces level
// - ordinary limiting starts after attack time elapses; look-ahead starts at once
// - release 1 to 500 ms after dropping
// - ordinary mode compresses twenty to one
// - hard knee leaves below-threshold untouched
// - soft knee starts six dB below threshold
// - ordinary threshold -16 to -2 dBFS
// - look-ahead detects peaks early, infinite ratio
// - look-ahead adds one millisecond delay
// - look-ahead output never exceeds target level
// - target level ignored outside look-ahead mode
// - limiter and 192 kHz rate exclude each other
// - linked pair sets both tracks limiting when either exceeds; each output follows its own level
// - limiting-active flag per track
`timescale 1ns/1ps
`include "ilhm_defs.vh"

module ilhm_top (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // audio in from converters
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [23:0] in_smp0,
  input  wire [23:0] in_smp1,
  // audio out to recorder and monitor mix
  output wire        out_valid,
  input  wire        out_ready,
  output wire [23:0] out_rec0,
  output wire [23:0] out_rec1,
  output wire [23:0] out_mon0,
  output wire [23:0] out_mon1,
  // limiting indicators
  output wire [1:0]  lim_active
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_ATK  = 4'b0010;
  localparam ST_LIM  = 4'b0100;
  localparam ST_REL  = 4'b1000;

  // ========================================================================
  // functions
  function [23:0] db_lin;
    input [4:0] d;
    begin
      case (d)
        5'h00: db_lin = 24'h7FFFFF;
        5'h01: db_lin = 24'h72147B;
        5'h02: db_lin = 24'h65AC84;
        5'h03: db_lin = 24'h5A9DF7;
        5'h04: db_lin = 24'h50C335;
        5'h05: db_lin = 24'h47FACC;
        5'h06: db_lin = 24'h4026E6;
        5'h07: db_lin = 24'h392CF7;
        5'h08: db_lin = 24'h32F536;
        5'h09: db_lin = 24'h2D6A87;
        5'h0A: db_lin = 24'h287A30;
        5'h0B: db_lin = 24'h241351;
        5'h0C: db_lin = 24'h2026FF;
        5'h0D: db_lin = 24'h1CA7E5;
        5'h0E: db_lin = 24'h198A22;
        5'h0F: db_lin = 24'h16C30F;
        5'h10: db_lin = 24'h14496F;
        5'h11: db_lin = 24'h1214EB;
        5'h12: db_lin = 24'h101D4D;
        5'h13: db_lin = 24'h0E5CAF;
        5'h14: db_lin = 24'h0CCCCD;
        5'h15: db_lin = 24'h0B6873;
        default: db_lin = 24'h0A2ADA;
      endcase
    end
  endfunction

  // excess above the threshold scaled by the ratio, kept wide to avoid wrap
  function [23:0] slope;
    input [23:0] d;
    reg   [31:0] p;
    begin
      p     = {8'h00, d} * {24'h000000, `ILHM_RATIO_NUM};
      slope = p[31:8];
    end
  endfunction

  function [6:0] spms;
    input [1:0] rate;
    begin
      spms = (rate == `ILHM_RATE_48K) ? `ILHM_SPMS_48K : `ILHM_SPMS_96K;
    end
  endfunction

  function [23:0] sat24;
    input signed [39:0] v;
    begin
      if (v > $signed({16'h0000, `ILHM_FULL}))
        sat24 = `ILHM_FULL;
      else if (v < -$signed({16'h0000, `ILHM_FULL}))
        sat24 = 24'h800001;
      else
        sat24 = v[23:0];
    end
  endfunction

  // ========================================================================
  // register storage
  reg  [4:0]  ctrl_r;
  reg         refused_r;
  reg  [15:0] tcfg_r  [0:1];
  reg  [12:0] lim_r   [0:1];
  reg  [24:0] time_r  [0:1];
  reg  [15:0] fader_r [0:1];
  reg         wr_pend_r;
  reg  [7:0]  wa_r;
  reg  [31:0] hrdata_r;
  reg  [31:0] rd_nxt;
  reg  [1:0]  lact_r;

  wire [7:0]  wa_off  = wa_r - `ILHM_A_TRK_BASE;
  wire        wa_trk  = (wa_r >= `ILHM_A_TRK_BASE) && (wa_off < {`ILHM_A_TRK_STEP, 1'b0});
  wire        wa_idx  = wa_off[4];
  wire [7:0]  ra      = haddr[7:0];
  wire [7:0]  ra_off  = ra - `ILHM_A_TRK_BASE;
  wire        ra_trk  = (ra >= `ILHM_A_TRK_BASE) && (ra_off < {`ILHM_A_TRK_STEP, 1'b0});
  wire        ra_idx  = ra_off[4];
  wire        any_on  = (tcfg_r[0][`ILHM_TC_MODE] != `ILHM_MODE_OFF) ||
                        (tcfg_r[1][`ILHM_TC_MODE] != `ILHM_MODE_OFF);
  wire        rate192 = (ctrl_r[`ILHM_CTRL_RATE] == `ILHM_RATE_192K);
  wire        take    = hsel & htrans[1] & hready;

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ========================================================================
  // read mux (answer captured in the address phase)
  always @* begin
    rd_nxt = 32'h0000_0000;
    if (ra == `ILHM_A_CTRL)
      rd_nxt = {27'h0, ctrl_r};
    else if (ra == `ILHM_A_STATUS)
      rd_nxt = {29'h0, refused_r, lact_r};
    else if (ra_trk) begin
      case (ra_off[3:0])
        `ILHM_O_TCFG:  rd_nxt = {16'h0, tcfg_r[ra_idx]};
        `ILHM_O_LIM:   rd_nxt = {19'h0, lim_r[ra_idx]};
        `ILHM_O_TIME:  rd_nxt = {7'h0, time_r[ra_idx]};
        `ILHM_O_FADER: rd_nxt = {16'h0, fader_r[ra_idx]};
        default:       rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // bus slave and register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r  <= 1'b0;
      wa_r       <= 8'h00;
      hrdata_r   <= 32'h0000_0000;
      ctrl_r     <= `ILHM_RST_CTRL;
      refused_r  <= 1'b0;
      tcfg_r[0]  <= `ILHM_RST_TCFG;
      tcfg_r[1]  <= `ILHM_RST_TCFG;
      lim_r[0]   <= `ILHM_RST_LIM;
      lim_r[1]   <= `ILHM_RST_LIM;
      time_r[0]  <= `ILHM_RST_TIME;
      time_r[1]  <= `ILHM_RST_TIME;
      fader_r[0] <= `ILHM_RST_FADER;
      fader_r[1] <= `ILHM_RST_FADER;
    end else begin
      wr_pend_r <= take & hwrite;
      if (take)
        wa_r <= ra;
      if (take & ~hwrite)
        hrdata_r <= rd_nxt;
      if (wr_pend_r) begin
        if (wa_r == `ILHM_A_STATUS && hwdata[`ILHM_ST_REFUSED])
          refused_r <= 1'b0;
        if (wa_r == `ILHM_A_CTRL) begin
          if (hwdata[`ILHM_CTRL_RATE] == `ILHM_RATE_192K && any_on) begin
            ctrl_r    <= {hwdata[4:2], ctrl_r[`ILHM_CTRL_RATE]};
            refused_r <= 1'b1;
          end else
            ctrl_r <= hwdata[4:0];
        end else if (wa_trk) begin
          case (wa_off[3:0])
            `ILHM_O_TCFG: begin
              if (rate192 && hwdata[`ILHM_TC_MODE] != `ILHM_MODE_OFF) begin
                tcfg_r[wa_idx] <= {hwdata[15:2], tcfg_r[wa_idx][`ILHM_TC_MODE]};
                refused_r      <= 1'b1;
              end else
                tcfg_r[wa_idx] <= hwdata[15:0];
            end
            `ILHM_O_LIM:   lim_r[wa_idx]   <= hwdata[12:0];
            `ILHM_O_TIME:  time_r[wa_idx]  <= hwdata[24:0];
            `ILHM_O_FADER: fader_r[wa_idx] <= hwdata[15:0];
            default: ;
          endcase
        end
      end
    end
  end

  // ========================================================================
  // sample path: hpf, limiter, fader, tap
  reg  [3:0]  st_r   [0:1];
  reg  [15:0] cnt_r  [0:1];
  reg  [23:0] x1_r   [0:1];
  reg  [23:0] y1_r   [0:1];
  reg  [23:0] dly_r  [0:2*`ILHM_DLY_DEPTH-1];
  reg  [6:0]  wp_r;
  reg  [95:0] e0_r;
  reg  [95:0] e1_r;
  reg  [1:0]  fill_r;
  reg         in_ready_r;
  reg         out_valid_r;

  reg  [3:0]  st_nxt  [0:1];
  reg  [15:0] cnt_nxt [0:1];
  reg  [23:0] hpf_y   [0:1];
  reg  [1:0]  over;
  reg  [95:0] res;
  reg  [1:0]  lact_nxt;
  reg  [1:0]  fill_nxt;
  reg  [6:0]  rd_idx;
  reg  [7:0]  hz;
  reg  [19:0] coef;
  reg  [11:0] kr;
  reg  [4:0]  thr_db;
  reg  [4:0]  tgt_db;
  reg  [23:0] thr_lin;
  reg  [23:0] knee_lin;
  reg  [23:0] tgt_lin;
  reg  [23:0] mag;
  reg  [23:0] dmag;
  reg  [23:0] lmag;
  reg  [23:0] xin;
  reg  [23:0] dsmp;
  reg  [23:0] lout;
  reg  [23:0] post;
  reg  [15:0] atk_n;
  reg  [15:0] rel_n;
  reg  [8:0]  rel_ms;
  reg  [1:0]  mode;
  reg         ovr_any;
  reg         limiting;
  reg  signed [39:0] acc;
  reg  signed [47:0] prod;
  integer     t;

  wire push = in_valid & in_ready_r;
  wire pop  = out_valid_r & out_ready;
  wire force_post = ctrl_r[`ILHM_CTRL_PLAY] & ctrl_r[`ILHM_CTRL_SCREEN];
  wire [6:0] la_len = spms(ctrl_r[`ILHM_CTRL_RATE]);

  assign in_ready   = in_ready_r;
  assign out_valid  = out_valid_r;
  assign out_rec0   = e0_r[23:0];
  assign out_rec1   = e0_r[47:24];
  assign out_mon0   = e0_r[71:48];
  assign out_mon1   = e0_r[95:72];
  assign lim_active = lact_r;

  always @* begin
    rd_idx = (wp_r >= la_len) ? wp_r - la_len : wp_r + 7'd`ILHM_DLY_DEPTH - la_len;
    case (ctrl_r[`ILHM_CTRL_RATE])
      `ILHM_RATE_48K: kr = `ILHM_KR_48K;
      `ILHM_RATE_96K: kr = `ILHM_KR_96K;
      default:        kr = `ILHM_KR_192K;
    endcase
    over = 2'b00;
    res  = 96'h0;
    lact_nxt = 2'b00;
    // high-pass first, then level detect on its output
    for (t = 0; t < 2; t = t + 1) begin
      xin = (t == 0) ? in_smp0 : in_smp1;
      hz  = tcfg_r[t][`ILHM_TC_HPF];
      if (hz < `ILHM_HPF_MIN && hz != 8'h00)
        hz = `ILHM_HPF_MIN;
      if (hz > `ILHM_HPF_MAX)
        hz = `ILHM_HPF_MAX;
      coef = hz * kr;
      prod = $signed({{24{y1_r[t][23]}}, y1_r[t]}) * $signed({28'h0, coef});
      acc  = $signed({{16{xin[23]}}, xin}) - $signed({{16{x1_r[t][23]}}, x1_r[t]})
           + $signed({{16{y1_r[t][23]}}, y1_r[t]}) - $signed(prod[47:24] );
      hpf_y[t] = (hz == 8'h00) ? xin : sat24(acc);
      mag  = hpf_y[t][23] ? (~hpf_y[t] + 24'h1) : hpf_y[t];
      if (mag > `ILHM_FULL)
        mag = `ILHM_FULL;
      thr_db = lim_r[t][`ILHM_LM_THR];
      if (thr_db < `ILHM_THR_MIN)
        thr_db = `ILHM_THR_MIN;
      if (thr_db > `ILHM_THR_MAX)
        thr_db = `ILHM_THR_MAX;
      tgt_db = lim_r[t][`ILHM_LM_TGT];
      if (tgt_db > `ILHM_TGT_MAX)
        tgt_db = `ILHM_TGT_MAX;
      thr_lin  = db_lin(thr_db);
      knee_lin = db_lin(thr_db + `ILHM_KNEE_DB);
      tgt_lin  = db_lin(tgt_db);
      mode = tcfg_r[t][`ILHM_TC_MODE];
      if (mode == `ILHM_MODE_NORM)
        over[t] = mag > (tcfg_r[t][`ILHM_TC_SOFT] ? knee_lin : thr_lin);
      else if (mode == `ILHM_MODE_ADV)
        over[t] = mag > tgt_lin;
    end
    for (t = 0; t < 2; t = t + 1) begin
      mode    = tcfg_r[t][`ILHM_TC_MODE];
      ovr_any = ctrl_r[`ILHM_CTRL_LINK] ? |over : over[t];
      atk_n   = time_r[t][`ILHM_TM_ATK] * la_len;
      rel_ms  = time_r[t][`ILHM_TM_REL];
      if (rel_ms < `ILHM_REL_MIN)
        rel_ms = `ILHM_REL_MIN;
      if (rel_ms > `ILHM_REL_MAX)
        rel_ms = `ILHM_REL_MAX;
      rel_n = rel_ms * la_len;
      st_nxt[t]  = st_r[t];
      cnt_nxt[t] = cnt_r[t];
      case (st_r[t])
        ST_IDLE: begin
          cnt_nxt[t] = 16'h0000;
          if (ovr_any)
            st_nxt[t] = (mode == `ILHM_MODE_ADV || atk_n == 16'h0000) ? ST_LIM : ST_ATK;
        end
        ST_ATK: begin
          if (!ovr_any)
            st_nxt[t] = ST_IDLE;
          else if (cnt_r[t] + 16'h1 >= atk_n)
            st_nxt[t] = ST_LIM;
          else
            cnt_nxt[t] = cnt_r[t] + 16'h1;
        end
        ST_LIM: begin
          cnt_nxt[t] = 16'h0000;
          if (!ovr_any)
            st_nxt[t] = ST_REL;
        end
        ST_REL: begin
          if (ovr_any) begin
            st_nxt[t]  = ST_LIM;
            cnt_nxt[t] = 16'h0000;
          end else if (cnt_r[t] + 16'h1 >= rel_n)
            st_nxt[t] = ST_IDLE;
          else
            cnt_nxt[t] = cnt_r[t] + 16'h1;
        end
        default: st_nxt[t] = ST_IDLE;
      endcase
      if (mode == `ILHM_MODE_OFF)
        st_nxt[t] = ST_IDLE;
      limiting = (st_nxt[t] == ST_LIM) || (st_nxt[t] == ST_REL);
      lact_nxt[t] = limiting;
      thr_db = lim_r[t][`ILHM_LM_THR];
      if (thr_db < `ILHM_THR_MIN)
        thr_db = `ILHM_THR_MIN;
      if (thr_db > `ILHM_THR_MAX)
        thr_db = `ILHM_THR_MAX;
      tgt_db = lim_r[t][`ILHM_LM_TGT];
      if (tgt_db > `ILHM_TGT_MAX)
        tgt_db = `ILHM_TGT_MAX;
      thr_lin  = db_lin(thr_db);
      knee_lin = db_lin(thr_db + `ILHM_KNEE_DB);
      tgt_lin  = db_lin(tgt_db);
      mag  = hpf_y[t][23] ? (~hpf_y[t] + 24'h1) : hpf_y[t];
      lmag = mag;
      if (tcfg_r[t][`ILHM_TC_SOFT]) begin
        if (mag > thr_lin)
          lmag = knee_lin + ((thr_lin - knee_lin) >> 1)
               + slope(mag - thr_lin);
        else if (mag > knee_lin)
          lmag = knee_lin + ((mag - knee_lin) >> 1);
      end else if (mag > thr_lin)
        lmag = thr_lin + slope(mag - thr_lin);
      dsmp = dly_r[t*`ILHM_DLY_DEPTH + rd_idx];
      dmag = dsmp[23] ? (~dsmp + 24'h1) : dsmp;
      case (mode)
        `ILHM_MODE_NORM:
          lout = limiting ? (hpf_y[t][23] ? ~lmag + 24'h1 : lmag) : hpf_y[t];
        `ILHM_MODE_ADV:
          lout = (dmag > tgt_lin) ? (dsmp[23] ? ~tgt_lin + 24'h1 : tgt_lin) : dsmp;
        default:
          lout = hpf_y[t];
      endcase
      prod = $signed({{24{lout[23]}}, lout}) * $signed({32'h0, fader_r[t]});
      post = sat24({{6{prod[47]}}, prod[47:`ILHM_UNITY_SH]});
      res[t*24 +: 24] = lout;
      res[48 + t*24 +: 24] = (tcfg_r[t][`ILHM_TC_PREFADER] && !force_post) ? lout : post;
    end
    fill_nxt = fill_r + {1'b0, push} - {1'b0, pop};
  end

  // ========================================================================
  // sample state, delay line and two-entry output buffer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (t = 0; t < 2; t = t + 1) begin
        st_r[t]  <= ST_IDLE;
        cnt_r[t] <= 16'h0000;
        x1_r[t]  <= 24'h000000;
        y1_r[t]  <= 24'h000000;
      end
      for (t = 0; t < 2*`ILHM_DLY_DEPTH; t = t + 1)
        dly_r[t] <= 24'h000000;
      wp_r        <= 7'h00;
      lact_r      <= 2'b00;
      e0_r        <= 96'h0;
      e1_r        <= 96'h0;
      fill_r      <= 2'h0;
      in_ready_r  <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      in_ready_r  <= (fill_nxt != 2'h2);
      out_valid_r <= (fill_nxt != 2'h0);
      fill_r      <= fill_nxt;
      if (push) begin
        for (t = 0; t < 2; t = t + 1) begin
          st_r[t]  <= st_nxt[t];
          cnt_r[t] <= cnt_nxt[t];
          x1_r[t]  <= (t == 0) ? in_smp0 : in_smp1;
          y1_r[t]  <= hpf_y[t];
          dly_r[t*`ILHM_DLY_DEPTH + wp_r] <= hpf_y[t];
        end
        wp_r   <= (wp_r == 7'd`ILHM_DLY_DEPTH - 7'h1) ? 7'h00 : wp_r + 7'h1;
        lact_r <= lact_nxt;
      end
      case (fill_r)
        2'h0: if (push) e0_r <= res;
        2'h1: begin
          if (push && pop)
            e0_r <= res;
          else if (push)
            e1_r <= res;
        end
        default: if (pop) e0_r <= e1_r;
      endcase
    end
  end

endmodule // ilhm_top

// ==== src/ilhm_defs.vh ====
// Purpose: constants for the input limiter / high-pass / monitor-tap block
// Assumes: AHB-Lite register bus, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef ILHM_DEFS_VH
`define ILHM_DEFS_VH

// ==========================================================================
// register map (byte addresses)
`define ILHM_A_CTRL      8'h00
`define ILHM_A_STATUS    8'h04
`define ILHM_A_TRK_BASE  8'h10
`define ILHM_A_TRK_STEP  8'h10
`define ILHM_O_TCFG      4'h0
`define ILHM_O_LIM       4'h4
`define ILHM_O_TIME      4'h8
`define ILHM_O_FADER     4'hC

// ==========================================================================
// fields
`define ILHM_CTRL_RATE   1:0
`define ILHM_CTRL_PLAY   2
`define ILHM_CTRL_SCREEN 3
`define ILHM_CTRL_LINK   4
`define ILHM_ST_REFUSED  2
`define ILHM_TC_MODE     1:0
`define ILHM_TC_SOFT     2
`define ILHM_TC_PREFADER 3
`define ILHM_TC_HPF      15:8
`define ILHM_LM_THR      4:0
`define ILHM_LM_TGT      12:8
`define ILHM_TM_ATK      7:0
`define ILHM_TM_REL      24:16

// ==========================================================================
// encodings
`define ILHM_MODE_OFF    2'h0
`define ILHM_MODE_NORM   2'h1
`define ILHM_MODE_ADV    2'h2
`define ILHM_RATE_48K    2'h0
`define ILHM_RATE_96K    2'h1
`define ILHM_RATE_192K   2'h2

// ==========================================================================
// reset values
`define ILHM_RST_CTRL    5'h00
`define ILHM_RST_TCFG    16'h0000
`define ILHM_RST_LIM     13'h0002
`define ILHM_RST_TIME    25'h0C8_0001
`define ILHM_RST_FADER   16'h4000

// ==========================================================================
// ranges and timing
`define ILHM_HPF_MIN     8'h0A
`define ILHM_HPF_MAX     8'hF0
`define ILHM_THR_MIN     5'h02
`define ILHM_THR_MAX     5'h10
`define ILHM_TGT_MAX     5'h10
`define ILHM_KNEE_DB     5'h06
`define ILHM_REL_MIN     9'h001
`define ILHM_REL_MAX     9'h1F4
`define ILHM_LA_MS       1
`define ILHM_SPMS_48K    7'h30
`define ILHM_SPMS_96K    7'h60
`define ILHM_DLY_DEPTH   96
`define ILHM_KR_48K      12'h894
`define ILHM_KR_96K      12'h44A
`define ILHM_KR_192K     12'h225
`define ILHM_FULL        24'h7FFFFF
`define ILHM_UNITY_SH    14
`define ILHM_RATIO_NUM   8'h0D
`endif

// ==== bench/ilhm_sva.sv ====
// Purpose: port checker for ilhm_top
// Assumes: one clock, async active-low reset
// Notes:   stream occupancy is tracked here from the handshakes
`timescale 1ns/1ps
module ilhm_sva (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // bus
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // stream
  input wire        in_valid,
  input wire        in_ready,
  input wire        out_valid,
  input wire        out_ready,
  input wire [23:0] out_rec0,
  input wire [23:0] out_mon0,
  input wire [1:0]  lim_active
);
  // ====
  // occupancy
  logic [1:0] occ_r;
  logic [1:0] occ_nxt;
  always @* begin
    occ_nxt = occ_r + {1'b0, in_valid & in_ready} - {1'b0, out_valid & out_ready};
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) occ_r <= 2'h0;
    else occ_r <= occ_nxt;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ====
  // properties
  property p_in_rdy;
    $past(hresetn) |-> in_ready == (occ_r != 2'h2);
  endproperty
  a_in_rdy: assert property (p_in_rdy) else $error("in_ready wrong for fill");
  property p_out_vld;
    $past(hresetn) |-> out_valid == (occ_r != 2'h0);
  endproperty
  a_out_vld: assert property (p_out_vld) else $error("out_valid wrong for fill");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_rec0) && $stable(out_mon0);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled output moved");
  property p_push;
    in_valid && in_ready && !out_valid |=> out_valid;
  endproperty
  a_push: assert property (p_push) else $error("accepted pair not shown");
  property p_full;
    !in_ready && !out_ready ##1 !out_ready |-> !in_ready;
  endproperty
  a_full: assert property (p_full) else $error("full buffer reopened");
  property p_lim_upd;
    !(in_valid && in_ready) |=> $stable(lim_active);
  endproperty
  a_lim_upd: assert property (p_lim_upd) else $error("flag moved without sample");
  property p_lim_rst;
    $rose(hresetn) |-> lim_active == 2'h0;
  endproperty
  a_lim_rst: assert property (p_lim_rst) else $error("flag set after reset");
  property p_okay;
    hresp == 1'b0 && hreadyout == 1'b1;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not okay");
  property p_rd_hold;
    !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  c_full: cover property (occ_r == 2'h2);
  c_both: cover property (lim_active == 2'h3);
  c_read: cover property (hsel && htrans[1] && !hwrite);
endmodule // ilhm_sva

// ==== bench/ilhm_src.sv ====
// Purpose: converter stand-in feeding ilhm_top
// Assumes: valid/ready stream, one pair per beat
// Notes:   released data lines show the inverse of the last word
`timescale 1ns/1ps
module ilhm_src (
  // clock
  input  wire         hclk,
  // stream
  input  wire         in_ready,
  output logic        in_valid,
  output logic [23:0] in_smp0,
  output logic [23:0] in_smp1
);
  initial begin
    in_valid = 1'b0;
    in_smp0  = 24'h0;
    in_smp1  = 24'h0;
  end
  // offer a pair after gap cycles and hold it until taken
  task send(input logic [23:0] a, input logic [23:0] b, input int gap, input bit last);
    int n;
    repeat (gap) @(posedge hclk);
    in_valid <= 1'b1;
    in_smp0  <= a;
    in_smp1  <= b;
    @(posedge hclk);
    for (n = 0; n < 200 && in_ready !== 1'b1; n++) @(posedge hclk);
    if (n == 200) tb_top.stall();
    if (last) begin
      in_valid <= 1'b0;
      in_smp0  <= ~a;
      in_smp1  <= ~b;
    end
  endtask
endmodule // ilhm_src

// ==== bench/tb_top.sv ====
// Purpose: self-checking bench for ilhm_top
// Assumes: 50 MHz hclk, 48 kHz sample timing in samples
// Notes:   one task per scenario
`timescale 1ns/1ps
`include "ilhm_defs.vh"
`define C(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, out_ready;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire         hready, hresp, in_valid, in_ready, out_valid;
  wire  [31:0] hrdata;
  wire  [23:0] in_smp0, in_smp1, r0, r1, m0, m1;
  wire  [1:0]  lim_active;
  logic [23:0] o0, o1, om, om1;
  logic [1:0]  ol;
  int          err_count, n_compared;
  ilhm_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .in_valid(in_valid),
    .in_ready(in_ready), .in_smp0(in_smp0), .in_smp1(in_smp1), .out_valid(out_valid),
    .out_ready(out_ready), .out_rec0(r0), .out_rec1(r1), .out_mon0(m0), .out_mon1(m1),
    .lim_active(lim_active));
  ilhm_src u_src (.hclk(hclk), .in_ready(in_ready), .in_valid(in_valid),
    .in_smp0(in_smp0), .in_smp1(in_smp1));
  // ====
  // support tasks
  task end_of_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task stall;
    err_count++;
    end_of_test();
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    for (n = 0; n < 50 && hready !== 1'b1; n++) @(posedge hclk);
    if (n == 50) stall();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    for (n = 0; n < 50 && hready !== 1'b1; n++) @(posedge hclk);
    if (n == 50) stall();
    q = hrdata;
  endtask
  task get;
    int n;
    @(posedge hclk);
    for (n = 0; n < 50 && out_valid !== 1'b1; n++) @(posedge hclk);
    if (n == 50) stall();
    o0 = r0;
    o1 = r1;
    om = m0;
    om1 = m1;
    ol = lim_active;
  endtask
  task xf(input logic [23:0] a, input logic [23:0] b);
    u_src.send(a, b, 0, 1'b1);
    get();
  endtask
  // ====
  // scenarios
  task t_regs;
    logic [7:0]  ra [7];
    logic [31:0] rv [7];
    ra = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h08};
    rv = '{32'h0, 32'h0, 32'h0, 32'h2, 32'h00C8_0001, 32'h4000, 32'h0};
    bus(8'h08, 1'b1, 32'hFFFF_FFFF);
    foreach (ra[i]) begin
      bus(ra[i], 1'b0, 32'h0);
      `C("reg", rv[i], q)
    end
  endtask
  task t_mon;
    bus(8'h1C, 1'b1, 32'h2000);
    xf(24'h10_0000, 24'h0);
    `C("rec", 24'h10_0000, o0)
    `C("post", 24'h08_0000, om)
    bus(8'h10, 1'b1, 32'h08);
    xf(24'h10_0000, 24'h20_0000);
    `C("pre", 24'h10_0000, om)
    `C("post1", 24'h20_0000, om1)
    bus(8'h00, 1'b1, 32'h0C);
    xf(24'h10_0000, 24'h0);
    `C("forced", 24'h08_0000, om)
    bus(8'h00, 1'b1, 32'h04);
    xf(24'h10_0000, 24'h0);
    `C("play", 24'h10_0000, om)
    bus(8'h20, 1'b1, 32'hF000);
    repeat (3) xf(24'h0, 24'h40_0000);
    `C("hpf", 1'b1, o1 < 24'h40_0000)
    bus(8'h20, 1'b1, 32'h0);
    bus(8'h00, 1'b1, 32'h0);
    bus(8'h1C, 1'b1, 32'h4000);
  endtask
  task idle;
    repeat (60) xf(24'h0, 24'h0);
  endtask
  task t_hard;
    bus(8'h14, 1'b1, 32'h0606);
    bus(8'h18, 1'b1, 32'h0001_0001);
    bus(8'h10, 1'b1, 32'h01);
    xf(24'h30_0000, 24'h0);
    `C("below", 24'h30_0000, o0)
    `C("below_act", 1'b0, ol[0])
    for (int i = 0; i < 60; i++) begin
      xf(24'h7F_0000, 24'h0);
      if (i == 40) `C("attack", 24'h7F_0000, o0)
      if (i == 40) `C("attack_act", 1'b0, ol[0])
    end
    `C("act", 1'b1, ol[0])
    `C("ratio", 1'b1, o0 > 24'h40_0000 && o0 < 24'h44_0000)
    xf(24'h10_0000, 24'h0);
    `C("release", 1'b1, ol[0])
    idle();
    `C("stopped", 1'b0, ol[0])
  endtask
  task t_soft;
    bus(8'h18, 1'b1, 32'h0001_0000);
    bus(8'h10, 1'b1, 32'h05);
    repeat (3) xf(24'h50_C335, 24'h0);
    `C("knee", 1'b1, o0 < 24'h50_C335)
    `C("knee_act", 1'b1, ol[0])
    idle();
  endtask
  task t_la;
    bus(8'h10, 1'b1, 32'h02);
    for (int k = 0; k < 100; k++) begin
      xf((k == 48) ? 24'h10_0000 : 24'h0, 24'h0);
      if (k >= 48) `C("delay", (k == 96) ? 24'h10_0000 : 24'h0, o0)
    end
    for (int k = 0; k < 60; k++) begin
      xf(24'h7F_0000, 24'h0);
      `C("target", 1'b1, o0 <= 24'h40_2700)
    end
    `C("la_act", 1'b1, ol[0])
    bus(8'h14, 1'b1, 32'h0602);
    bus(8'h10, 1'b1, 32'h01);
    idle();
    xf(24'h60_0000, 24'h0);
    `C("no_target", 24'h60_0000, o0)
  endtask
  task t_rate;
    bus(8'h00, 1'b1, 32'h02);
    bus(8'h00, 1'b0, 32'h0);
    `C("rate_kept", 2'h0, q[1:0])
    bus(8'h04, 1'b0, 32'h0);
    `C("refused", 1'b1, q[2])
    bus(8'h04, 1'b1, 32'h04);
    bus(8'h04, 1'b0, 32'h0);
    `C("cleared", 1'b0, q[2])
    bus(8'h10, 1'b1, 32'h0);
    bus(8'h20, 1'b1, 32'h0);
    bus(8'h00, 1'b1, 32'h02);
    bus(8'h20, 1'b1, 32'h01);
    bus(8'h20, 1'b0, 32'h0);
    `C("mode_kept", 2'h0, q[1:0])
    bus(8'h04, 1'b0, 32'h0);
    `C("refused2", 1'b1, q[2])
    bus(8'h00, 1'b1, 32'h0);
    bus(8'h04, 1'b1, 32'h04);
  endtask
  task t_buf;
    out_ready <= 1'b0;
    u_src.send(24'h12_3456, 24'h65_4321, 3, 1'b0);
    u_src.send(24'h0A_BCDE, 24'h7E_DCBA, 0, 1'b1);
    @(posedge hclk);
    `C("full", 1'b0, in_ready)
    out_ready <= 1'b1;
    get();
    `C("first", 48'h12_3456_65_4321, {o0, o1})
    get();
    `C("second", 48'h0A_BCDE_7E_DCBA, {o0, o1})
  endtask
  task t_link;
    bus(8'h00, 1'b1, 32'h10);
    bus(8'h24, 1'b1, 32'h0606);
    bus(8'h28, 1'b1, 32'h0001_0000);
    bus(8'h20, 1'b1, 32'h01);
    bus(8'h18, 1'b1, 32'h0001_0000);
    repeat (2) xf(24'h7F_0000, 24'h00_1000);
    `C("linked", 2'h3, ol)
  endtask
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    out_ready = 1'b1;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_mon();
    t_buf();
    t_hard();
    t_soft();
    t_la();
    t_link();
    t_rate();
    end_of_test();
  end
endmodule // tb_top
bind ilhm_top ilhm_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
  .out_rec0(out_rec0), .out_mon0(out_mon0), .lim_active(lim_active));
